// ---- rtl/cdi_pkg.sv ----
// What this block does
// (R01) Station number is tens switch times ten plus units switch.
// (R02) Selector 0..7 gives normal operation, 8..F gives input mirroring mode.
// (R03) Selector low three bits pick 10,20,50,125,250,500,800,1000 kbit/s.
// (R04) In mirroring mode each sensed input drives the partner's same output.
// (R05) Partner is odd station plus one; adjacency identifies the partner.
// (R06) Both pair nodes must use a selector in the mirroring range.
// (R07) Mirroring mode enters Operational by itself, no master start needed.
// (R08) Run indicator dark without supply; single flash while Stopped.
// (R09) Run indicator blinks continuously while Pre-operational.
// (R10) Run indicator lit steadily while Operational.
// (R11) Error indicator dark while no communication error is present.
// (R12) Error indicator single flash after at least one network error.
// (R13) Error indicator double flash after a guarding failure.
// (R14) Error indicator lit steadily while the controller is bus-off.
// (R15) Terminator indicator follows the termination enable.
// (R16) Channel indicators follow raw inputs, ignoring polarity inversion.
// (R17) Phases of 200 ms for flashes and blinks, 1000 ms dark gap.
// (R18) Switches are captured once after reset and held until next reset.
package cdi_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned PHASE_MS = 200;
   localparam int unsigned GAP_MS = 1000;
   localparam int unsigned PHASE_CYC = PHASE_MS * 1000 * CLK_MHZ;
   localparam int unsigned GAP_CYC = GAP_MS * 1000 * CLK_MHZ;
   localparam logic [3:0] MIRROR_SEL_MIN = 4'h8;
   // Register byte addresses
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_CTRL = 8'h04;
   localparam logic [7:0] A_CONFIG = 8'h08;
   localparam logic [7:0] A_INPUTS = 8'h0c;
   localparam logic [7:0] A_IRQ_STAT = 8'h10;
   localparam logic [7:0] A_IRQ_MASK = 8'h14;
   localparam logic [7:0] A_MIRROR = 8'h18;
   // Control fields
   localparam int unsigned C_NMT_LSB = 0;
   localparam int unsigned C_TERM = 2;
   localparam int unsigned C_NETERR = 3;
   localparam int unsigned C_GUARD = 4;
   localparam int unsigned C_BUSOFF = 5;
   localparam int unsigned C_POL_LSB = 16;
   // Request field starts at Pre-operational so reset state is not overridden
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   // Interrupt bits
   localparam int unsigned I_CHANGE = 0;
   localparam int unsigned I_NMT = 1;
   localparam int unsigned I_MIRROR = 2;
   typedef enum logic [1:0] {NMT_STOP, NMT_PREOP, NMT_OPER} cdi_nmt_t;
endpackage

// ---- rtl/cdi_node.sv ----
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module cdi_node
   import cdi_pkg::*;
#(
   parameter int unsigned PHASE_CYCLES = cdi_pkg::PHASE_CYC,
   parameter int unsigned GAP_CYCLES   = cdi_pkg::GAP_CYC
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [3:0]  sw_tens,
   input  wire logic [3:0]  sw_units,
   input  wire logic [3:0]  sw_rate,
   input  wire logic [15:0] input_channel,
   input  wire logic        supply_ok,
   output logic      [6:0]  station_number,
   output logic      [2:0]  rate_index,
   output logic             mirror_mode,
   output logic      [6:0]  partner_number,
   output logic      [15:0] mirror_outputs,
   output logic             mirror_valid,
   output logic      [15:0] input_led,
   output logic             run_led,
   output logic             err_led,
   output logic             term_led,
   output logic             irq
);
   import cdi_pkg::*;

   logic [15:0] in_s1_q, in_s2_q, in_prev_q;
   logic [11:0] sw_s1_q, sw_s2_q;
   logic        sup_s1_q, sup_s2_q;
   logic [1:0]  cap_cnt_q;
   logic        captured_q;
   logic [3:0]  rate_sel_q;
   logic [31:0] ctrl_q;
   logic [2:0]  ist_q, imask_q;
   cdi_nmt_t    nmt_q;
   logic [31:0] ph_cnt_q;
   logic [2:0]  step_q;
   logic        ph_tick;
   logic        wr_pend_q, rd_pend_q;
   logic [7:0]  addr_q;

   // Synchronisers: stage one read only by stage two
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         in_s1_q  <= 16'h0000;
         in_s2_q  <= 16'h0000;
         sw_s1_q  <= 12'h000;
         sw_s2_q  <= 12'h000;
         sup_s1_q <= 1'b0;
         sup_s2_q <= 1'b0;
      end
      else
      begin
         in_s1_q  <= input_channel;
         in_s2_q  <= in_s1_q;
         sw_s1_q  <= {sw_tens, sw_units, sw_rate};
         sw_s2_q  <= sw_s1_q;
         sup_s1_q <= supply_ok;
         sup_s2_q <= sup_s1_q;
      end

   // Switch capture after release, once synchronisers have filled
   wire [3:0] tens_w  = sw_s2_q[11:8];
   wire [3:0] units_w = sw_s2_q[7:4];
   wire [6:0] id_w    = ({3'b000, tens_w} * 7'd10) + {3'b000, units_w}; // [R01]
   wire       cap_now = !captured_q && cap_cnt_q == 2'd3;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         cap_cnt_q      <= 2'd0;
         captured_q     <= 1'b0;
         station_number <= 7'h00;
         rate_sel_q     <= 4'h0;
      end
      else
      begin
         if (cap_cnt_q != 2'd3)
            cap_cnt_q <= cap_cnt_q + 2'd1;
         if (cap_now) // [R18]
         begin
            captured_q     <= 1'b1;
            station_number <= id_w;
            rate_sel_q     <= sw_s2_q[3:0];
         end
      end

   wire mirror_w = rate_sel_q >= MIRROR_SEL_MIN; // [R02]
   // Odd node pairs upward, even node pairs downward
   wire [6:0] partner_w = station_number[0] ? station_number + 7'd1
                                            : station_number - 7'd1; // [R05]

   // Network state; mirroring forces Operational
   wire       ctl_wr   = wr_pend_q && addr_q == A_CTRL;
   wire [1:0] nmt_req  = ctrl_q[C_NMT_LSB +: 2];
   cdi_nmt_t  nmt_d;
   assign nmt_d = (captured_q && mirror_w) ? NMT_OPER : // [R07]
                  nmt_req == 2'd2 ? NMT_OPER :
                  nmt_req == 2'd1 ? NMT_PREOP : NMT_STOP;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         nmt_q <= NMT_PREOP;
      else if (captured_q)
         nmt_q <= nmt_d;

   // Pattern timebase: 200 ms steps; steps 3..7 form the 1000 ms gap
   localparam int unsigned GAP_STEPS = GAP_CYCLES / PHASE_CYCLES;
   // Single flash repeats every six steps, double flash every eight
   logic [2:0] sgl_q;
   assign ph_tick = ph_cnt_q == PHASE_CYCLES - 1;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         ph_cnt_q <= 32'h0000_0000;
         step_q   <= 3'd0;
         sgl_q    <= 3'd0;
      end
      else
      begin
         ph_cnt_q <= ph_tick ? 32'h0000_0000 : ph_cnt_q + 32'h0000_0001; // [R17]
         if (ph_tick)
         begin
            step_q <= (32'(step_q) >= 3 + GAP_STEPS - 1) ? 3'd0 : step_q + 3'd1;
            sgl_q  <= (32'(sgl_q) >= GAP_STEPS) ? 3'd0 : sgl_q + 3'd1; // [R17]
         end
      end
   // Single flash: on at first of six; double: on at steps 0 and 2; blink: alternate
   wire single_w = sgl_q == 3'd0;
   wire double_w = step_q == 3'd0 || step_q == 3'd2;
   wire blink_w  = step_q[0] == 1'b0;

   wire run_d = !sup_s2_q               ? 1'b0 :     // [R08]
                nmt_q == NMT_OPER       ? 1'b1 :     // [R10]
                nmt_q == NMT_PREOP      ? blink_w :  // [R09]
                                          single_w;  // [R08]
   wire err_d = ctrl_q[C_BUSOFF] ? 1'b1 :            // [R14]
                ctrl_q[C_GUARD]  ? double_w :        // [R13]
                ctrl_q[C_NETERR] ? single_w :        // [R12]
                                   1'b0;             // [R11]

   // Mirroring image: raw inputs to paired outputs, 1:1
   wire mir_act = mirror_w && nmt_q == NMT_OPER;
   wire changed = in_s2_q != in_prev_q;

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         run_led        <= 1'b0;
         err_led        <= 1'b0;
         term_led       <= 1'b0;
         input_led      <= 16'h0000;
         in_prev_q      <= 16'h0000;
         mirror_outputs <= 16'h0000;
         mirror_valid   <= 1'b0;
         mirror_mode    <= 1'b0;
         rate_index     <= 3'd0;
         partner_number <= 7'h00;
      end
      else
      begin
         run_led        <= run_d;
         err_led        <= err_d;
         term_led       <= ctrl_q[C_TERM];             // [R15]
         input_led      <= in_s2_q;                    // [R16]
         in_prev_q      <= in_s2_q;
         mirror_outputs <= mir_act ? in_s2_q : 16'h0000; // [R04]
         mirror_valid   <= mir_act && changed;
         mirror_mode    <= mirror_w;
         rate_index     <= rate_sel_q[2:0];            // [R03]
         partner_number <= partner_w;
      end

   // AHB-Lite slave, zero wait states on writes, one wait state on reads
   wire       take   = hsel && hready && htrans[1];
   wire       rd_hit = addr_q inside {A_STATUS, A_CTRL, A_CONFIG, A_INPUTS,
                                      A_IRQ_STAT, A_IRQ_MASK, A_MIRROR};
   wire [2:0] ev     = {mirror_valid, nmt_q != nmt_d && captured_q, changed};
   wire [2:0] w1c    = (wr_pend_q && addr_q == A_IRQ_STAT) ? hwdata[2:0] : 3'b000;
   wire [31:0] rd_w =
      addr_q == A_STATUS   ? {27'h0, sup_s2_q, captured_q, mirror_w, 2'(nmt_q)} :
      addr_q == A_CTRL     ? ctrl_q :
      addr_q == A_CONFIG   ? {16'h0, 5'h0, partner_number, rate_sel_q} |
                             {9'h0, station_number, 16'h0} :
      addr_q == A_INPUTS   ? {ctrl_q[31:16] ^ in_s2_q, in_s2_q} :
      addr_q == A_IRQ_STAT ? {29'h0, ist_q} :
      addr_q == A_IRQ_MASK ? {29'h0, imask_q} :
      addr_q == A_MIRROR   ? {15'h0, mirror_valid, mirror_outputs} : 32'h0;

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
         hrdata    <= 32'h0000_0000;
         ctrl_q    <= CTRL_RST;
         ist_q     <= 3'b000;
         imask_q   <= 3'b000;
         irq       <= 1'b0;
      end
      else
      begin
         wr_pend_q <= take && hwrite;
         rd_pend_q <= take && !hwrite;
         if (take)
            addr_q <= haddr[7:0];
         if (ctl_wr)
            ctrl_q <= hwdata;
         if (wr_pend_q && addr_q == A_IRQ_MASK)
            imask_q <= hwdata[2:0];
         // Set beats clear in the same cycle
         ist_q  <= (ist_q & ~w1c) | ev;
         irq    <= |(((ist_q & ~w1c) | ev) & imask_q);
         // Loaded in the wait state, held until the next read
         if (rd_pend_q)
            hrdata <= rd_hit ? rd_w : 32'h0000_0000;
      end

   // One wait state on reads keeps hrdata straight from a flop
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= !(take && !hwrite) || rd_pend_q;
         hresp     <= 1'b0;
      end

   // Assertions
   sequence s_rd_addr;
      take && !hwrite;
   endsequence
   sequence s_rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_rd_wait;
      @(posedge hclk) disable iff (!hresetn)
      s_rd_addr |=> s_rd_answer;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
   property p_wr_zero;
      @(posedge hclk) disable iff (!hresetn)
      (take && hwrite) |=> hreadyout;
   endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
   property p_resp_ok;
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |-> !hresp;
   endproperty
   a_resp_ok: assert property (p_resp_ok) else $error("error response");
   property p_set_wins;
      @(posedge hclk) disable iff (!hresetn)
      ev[I_CHANGE] |=> ist_q[I_CHANGE];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost");
   property p_station;
      @(posedge hclk) disable iff (!hresetn)
      cap_now |=> station_number == $past(id_w);
   endproperty
   a_station: assert property (p_station) else $error("bad station"); // [R01]
   property p_rate;
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> rate_index == $past(rate_sel_q[2:0]);
   endproperty
   a_rate: assert property (p_rate) else $error("rate wrong"); // [R03]
   property p_run_stop;
      @(posedge hclk) disable iff (!hresetn)
      (sup_s2_q && nmt_q == NMT_STOP) |=> run_led == $past(single_w);
   endproperty
   a_run_stop: assert property (p_run_stop) else $error("stop pattern"); // [R08]
   property p_run_blink;
      @(posedge hclk) disable iff (!hresetn)
      (sup_s2_q && nmt_q == NMT_PREOP) |=> run_led == $past(blink_w);
   endproperty
   a_run_blink: assert property (p_run_blink) else $error("blink pattern"); // [R09]
   property p_err_warn;
      @(posedge hclk) disable iff (!hresetn)
      ctrl_q[5:3] == 3'b001 |=> err_led == $past(single_w);
   endproperty
   a_err_warn: assert property (p_err_warn) else $error("warn pattern"); // [R12]
   property p_err_guard;
      @(posedge hclk) disable iff (!hresetn)
      ctrl_q[5:4] == 2'b01 |=> err_led == $past(double_w);
   endproperty
   a_err_guard: assert property (p_err_guard) else $error("guard pattern"); // [R13]
   property p_phase;
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |-> ph_cnt_q < PHASE_CYCLES && 32'(sgl_q) <= GAP_STEPS;
   endproperty
   a_phase: assert property (p_phase) else $error("timebase overrun"); // [R17]
   property p_mirror_off;
      @(posedge hclk) disable iff (!hresetn)
      !mir_act |=> mirror_outputs == 16'h0000;
   endproperty
   a_mirror_off: assert property (p_mirror_off) else $error("mirror leak"); // [R04]
   property p_partner_even;
      @(posedge hclk) disable iff (!hresetn)
      captured_q && !station_number[0] |=> ##1 partner_number == station_number - 7'd1;
   endproperty
   a_partner_even: assert property (p_partner_even) else $error("bad partner"); // [R05]
   property p_run_oper;
      @(posedge hclk) disable iff (!hresetn)
      (sup_s2_q && nmt_q == NMT_OPER) |=> run_led;
   endproperty
   a_run_oper: assert property (p_run_oper) else $error("run not lit"); // [R10]
   property p_run_nosup;
      @(posedge hclk) disable iff (!hresetn)
      !sup_s2_q |=> !run_led;
   endproperty
   a_run_nosup: assert property (p_run_nosup) else $error("run lit"); // [R08]
   property p_err_busoff;
      @(posedge hclk) disable iff (!hresetn)
      ctrl_q[C_BUSOFF] |=> err_led;
   endproperty
   a_err_busoff: assert property (p_err_busoff) else $error("bus-off dark"); // [R14]
   property p_err_none;
      @(posedge hclk) disable iff (!hresetn)
      ctrl_q[5:3] == 3'b000 |=> !err_led;
   endproperty
   a_err_none: assert property (p_err_none) else $error("err lit"); // [R11]
   property p_led_raw;
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> input_led == $past(in_s2_q);
   endproperty
   a_led_raw: assert property (p_led_raw) else $error("led mismatch"); // [R16]
   property p_term;
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> term_led == $past(ctrl_q[C_TERM]);
   endproperty
   a_term: assert property (p_term) else $error("term mismatch"); // [R15]
   property p_auto_oper;
      @(posedge hclk) disable iff (!hresetn)
      (captured_q && mirror_w) |=> nmt_q == NMT_OPER;
   endproperty
   a_auto_oper: assert property (p_auto_oper) else $error("not oper"); // [R07]
   property p_hold;
      @(posedge hclk) disable iff (!hresetn)
      captured_q |=> $stable(station_number) && $stable(rate_sel_q);
   endproperty
   a_hold: assert property (p_hold) else $error("switch moved"); // [R18]
   property p_partner;
      @(posedge hclk) disable iff (!hresetn)
      captured_q && station_number[0] |=> ##1 partner_number == station_number + 7'd1;
   endproperty
   a_partner: assert property (p_partner) else $error("bad partner"); // [R05]
   property p_mirror;
      @(posedge hclk) disable iff (!hresetn)
      mir_act |=> mirror_outputs == $past(in_s2_q);
   endproperty
   a_mirror: assert property (p_mirror) else $error("mirror wrong"); // [R04]
   property p_mode;
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> mirror_mode == $past(rate_sel_q[3]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode wrong"); // [R02]
endmodule

// ---- verif/cdi_pair_out_model.sv ----
`timescale 1ns/1ps
module cdi_pair_out_model
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [6:0]  own_number,
   input  wire logic [6:0]  peer_number,
   input  wire logic        peer_mirror,
   input  wire logic        mirror_valid,
   input  wire logic [15:0] mirror_outputs,
   output logic      [15:0] out_q
);
   // Obeys only its adjacent peer in the mirroring range
   wire accept = peer_mirror & mirror_valid & (peer_number == own_number);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         out_q <= 16'h0000;
      else if (accept)
         out_q <= mirror_outputs;
   end
endmodule

// ---- verif/cdi_node_tb_top.sv ----
`timescale 1ns/1ps
module cdi_node_tb_top;
   import cdi_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, supply_ok;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, rate_index;
   logic [3:0]  sw_tens, sw_units, sw_rate;
   logic [15:0] input_channel, mirror_outputs, input_led, peer_out;
   logic [6:0]  station_number, partner_number, own_number;
   logic        mirror_mode, mirror_valid, run_led, err_led, term_led, irq;
   logic [31:0] seed = 32'd60700;
   int          error_cnt = 0, comparisons = 0, cyc = 0, t, u, c;
   assign hready = hreadyout;
   cdi_node #(.PHASE_CYCLES(8), .GAP_CYCLES(40)) uut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .sw_tens(sw_tens), .sw_units(sw_units), .sw_rate(sw_rate),
      .input_channel(input_channel), .supply_ok(supply_ok),
      .station_number(station_number), .rate_index(rate_index),
      .mirror_mode(mirror_mode), .partner_number(partner_number),
      .mirror_outputs(mirror_outputs), .mirror_valid(mirror_valid),
      .input_led(input_led), .run_led(run_led), .err_led(err_led),
      .term_led(term_led), .irq(irq));
   cdi_pair_out_model peer (.hclk(hclk), .hresetn(hresetn), .own_number(own_number),
      .peer_number(partner_number), .peer_mirror(mirror_mode),
      .mirror_valid(mirror_valid), .mirror_outputs(mirror_outputs), .out_q(peer_out));
   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Odd station pairs upward, even one downward
   function automatic logic [6:0] exp_partner(input int s);
      return 7'((s % 2) ? s + 1 : s - 1);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic do_reset(input int st, input int su, input int sr);
      sw_tens <= 4'(st);
      sw_units <= 4'(su);
      sw_rate <= 4'(sr);
      own_number <= exp_partner(st * 10 + su);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
   endtask
   // Whole periods give exact lit counts whatever the phase
   task automatic lit(input int n, input bit e);
      c = 0;
      repeat (60) @(posedge hclk);
      repeat (n) @(posedge hclk) c += e ? err_led : run_led;
   endtask
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         error_cnt++;
         end_sim();
      end
   end
   initial
   begin
      {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
      {sw_tens, sw_units, sw_rate, own_number} = '0;
      hresetn = 1'b0;
      supply_ok = 1'b1;
      input_channel = 16'h0000;
      for (int s = 0; s < 16; s++)
      begin
         t = rnd() % 10;
         u = 1 + rnd() % 9;
         do_reset(t, u, s);
         chk(station_number, t * 10 + u);
         chk(rate_index, s % 8);
         chk(mirror_mode, s >= 8);
         chk(partner_number, exp_partner(t * 10 + u));
         ahb(1'b0, A_STATUS, 32'h0);
         if (s >= 8) chk(rd[1:0], NMT_OPER);
         sw_tens <= 4'(rnd() % 10);
         sw_rate <= 4'(s ^ 8);
         repeat (8) @(posedge hclk);
         chk(station_number, t * 10 + u);
         chk(mirror_mode, s >= 8);
      end
      input_channel <= 16'(rnd());
      repeat (10) @(posedge hclk);
      chk(peer_out, input_channel);
      chk(mirror_outputs, input_channel);
      do_reset(0, 2, 3);
      lit(160, 0);
      chk(c, 80);
      ahb(1'b1, A_CTRL, 32'hffff_0004);
      input_channel <= 16'(rnd());
      lit(480, 0);
      chk(c, 80);
      chk(input_led, input_channel);
      chk(term_led, 1);
      chk(err_led, 0);
      ahb(1'b0, A_INPUTS, 32'h0);
      chk(rd[15:0], input_channel);
      chk(peer_out, 0);
      ahb(1'b1, A_CTRL, 32'h0000_000a);
      lit(480, 1);
      chk(c, 80);
      chk(term_led, 0);
      lit(200, 0);
      chk(c, 200);
      ahb(1'b1, A_CTRL, 32'h0000_0012);
      lit(640, 1);
      chk(c, 160);
      ahb(1'b1, A_CTRL, 32'h0000_0022);
      lit(200, 1);
      chk(c, 200);
      supply_ok <= 1'b0;
      lit(200, 0);
      chk(c, 0);
      ahb(1'b1, A_IRQ_STAT, 32'h0000_0007);
      ahb(1'b1, A_IRQ_MASK, 32'h0000_0001);
      input_channel <= ~input_channel;
      repeat (8) @(posedge hclk);
      chk(irq, 1);
      ahb(1'b1, A_IRQ_STAT, 32'h0000_0007);
      ahb(1'b1, A_IRQ_MASK, 32'h0000_0000);
      input_channel <= ~input_channel;
      repeat (8) @(posedge hclk);
      chk(irq, 0);
      ahb(1'b0, A_IRQ_STAT, 32'h0);
      chk(rd[I_CHANGE], 1);
      ahb(1'b1, A_IRQ_STAT, 32'h0000_0001);
      ahb(1'b0, A_IRQ_STAT, 32'h0);
      chk(rd[I_CHANGE], 0);
      ahb(1'b0, 8'h1c, 32'h0);
      chk(rd, 0);
      chk(hresp, 0);
      end_sim();
   end
endmodule
